// [task_file_params.svh]
// Constants of the disk-compatible task file register bank.
// Included by the package and the register bank; holds definitions only.
`ifndef TASK_FILE_PARAMS_SVH
`define TASK_FILE_PARAMS_SVH

// Register offsets on address lines 2..0
`define OFS_DATA 3'h0
`define OFS_ERR_FEATURE 3'h1
`define OFS_SECTOR_COUNT 3'h2
`define OFS_SECTOR_NUMBER 3'h3
`define OFS_CYL_LOW 3'h4
`define OFS_CYL_HIGH 3'h5
`define OFS_UNIT_HEAD 3'h6
`define OFS_STATUS_CMD 3'h7
// Alternate chip select locations
`define OFS_ALT_STATUS 3'h6
`define OFS_ALT_RESERVED 3'h7

// Error register fields
`define ERR_BAD_BLOCK_BIT 7
`define ERR_UNCORRECTABLE_BIT 6
`define ERR_ID_MISSING_BIT 4
`define ERR_ABORTED_BIT 2
`define ERR_GENERAL_BIT 0
`define ERR_RESERVED_MASK 8'hAA

// Unit/head register fields
`define UH_LBA_BIT 6
`define UH_UNIT_BIT 4
`define UH_FIXED_ONES 8'hA0

// Reset values
`define RST_ERR 8'h00
`define RST_BYTE 8'h00
`define RST_UNIT_HEAD 8'hA0

// A zero sector count means this many sectors
`define SECTOR_COUNT_ZERO_MEANS 9'h100

`endif

// [task_file_pkg.sv]
// Types shared by the task file register bank and its users.
// Assumes task_file_params.svh is on the include path.
`include "task_file_params.svh"

package task_file_pkg;

   // Host disk controller pins, sampled on ref_clk
   typedef struct packed {
      logic primaryCsN;
      logic alternateCsN;
      logic [2:0] addr;
      logic iordN;
      logic iowrN;
      logic byteAccess;
      logic [15:0] wrData;
   } host_bus_t;

   // Outcome events of the card's media and command engine
   typedef struct packed {
      logic uncorrectable;
      logic idMissing;
      logic aborted;
      logic general;
      logic diagDone;
      logic [7:0] diagCode;
      logic errClear;
   } media_event_t;

   // Whole state of the register bank
   typedef struct packed {
      logic strapDone;
      logic trueIde;
      logic iordPrev;
      logic iowrPrev;
      logic [7:0] featureSel;
      logic [7:0] sectorCount;
      logic [7:0] sectorNumber;
      logic [7:0] cylLow;
      logic [7:0] cylHigh;
      logic [7:0] unitHead;
      logic [7:0] errCause;
      logic errDiag;
      logic [15:0] rdData;
      logic rdOe;
      logic dataWrStrobe;
      logic [15:0] dataWrWord;
      logic dataWrByte;
      logic dataRdStrobe;
      logic [8:0] sectorTotal;
      logic [27:0] mediaAddress;
      logic unitAddressed;
      logic statusValid;
   } tf_state_t;

endpackage

// [task_file_regs.sv]
// Task file register bank of the card's disk-compatible I/O mode.
// Assumes host strobes are already synchronous to ref_clk and that the
// media engine supplies read data for the data port in the strobe cycle.
`timescale 1ns/1ps
`default_nettype none
`include "task_file_params.svh"

module task_file_regs (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic outputEnableStrapN,
   input wire task_file_pkg::host_bus_t hostBus,
   input wire task_file_pkg::media_event_t mediaEvent,
   input wire logic [15:0] bufferRdWord,
   input wire logic copyNumber,
   input wire logic busyFlag,
   output logic [15:0] hostRdData,
   output logic hostRdOe,
   output logic dataWrStrobe,
   output logic [15:0] dataWrWord,
   output logic dataWrByte,
   output logic dataRdStrobe,
   output logic [7:0] featureSelect,
   output logic [8:0] sectorTotal,
   output logic [27:0] mediaAddress,
   output logic lbaMode,
   output logic unitAddressed,
   output logic trueIdeMode,
   output logic statusValid
);
   import task_file_pkg::*;

   tf_state_t q;
   tf_state_t d;

   // ----------------------------------------------------------------
   // Strobe decode
   // ----------------------------------------------------------------
   logic rdStart;
   logic wrStart;
   logic priSel;
   logic altSel;

   always_comb begin
      // Strobes act on their falling edge so one access is one event
      priSel = !hostBus.primaryCsN && hostBus.alternateCsN;
      altSel = hostBus.primaryCsN && !hostBus.alternateCsN;
      rdStart = q.trueIde && q.iordPrev && !hostBus.iordN;
      wrStart = q.trueIde && q.iowrPrev && !hostBus.iowrN;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [7:0] wrByteVal;
   logic [7:0] errNext;

   always_comb begin
      d = q;
      wrByteVal = hostBus.wrData[7:0];
      errNext = q.errCause;
      d.iordPrev = hostBus.iordN;
      d.iowrPrev = hostBus.iowrN;
      d.dataWrStrobe = 1'b0;
      d.dataRdStrobe = 1'b0;

      // Mode strap is caught once, in the first cycle after reset release
      if (!q.strapDone) begin
         d.strapDone = 1'b1;
         d.trueIde = !outputEnableStrapN;
      end

      // Host writes; a card not addressed still latches them
      if (wrStart && priSel) begin
         case (hostBus.addr)
            `OFS_DATA: begin
               d.dataWrStrobe = 1'b1;
               d.dataWrByte = hostBus.byteAccess;
               d.dataWrWord = hostBus.byteAccess ? {8'h00, wrByteVal} : hostBus.wrData;
            end
            `OFS_ERR_FEATURE: d.featureSel = wrByteVal;
            `OFS_SECTOR_COUNT: d.sectorCount = wrByteVal;
            `OFS_SECTOR_NUMBER: d.sectorNumber = wrByteVal;
            `OFS_CYL_LOW: d.cylLow = wrByteVal;
            `OFS_CYL_HIGH: d.cylHigh = wrByteVal;
            `OFS_UNIT_HEAD: d.unitHead = wrByteVal | `UH_FIXED_ONES;
            default: ;
         endcase
      end
      // Alternate writes (device control, reserved) belong elsewhere;
      // the reserved location in particular changes nothing here
      if (wrStart && altSel && hostBus.addr == `OFS_ALT_RESERVED) begin
         d.featureSel = q.featureSel;
      end

      // Error register: clear first so a same-cycle event still lands
      if (mediaEvent.errClear) begin
         errNext = `RST_ERR;
         d.errDiag = 1'b0;
      end
      if (mediaEvent.uncorrectable) begin
         errNext[`ERR_UNCORRECTABLE_BIT] = 1'b1;
      end
      if (mediaEvent.idMissing) begin
         errNext[`ERR_ID_MISSING_BIT] = 1'b1;
      end
      if (mediaEvent.aborted) begin
         errNext[`ERR_ABORTED_BIT] = 1'b1;
      end
      if (mediaEvent.general) begin
         errNext[`ERR_GENERAL_BIT] = 1'b1;
      end
      if (mediaEvent.diagDone) begin
         // Second-unit failure codes are never produced by this card
         errNext = {1'b0, mediaEvent.diagCode[6:0]};
         d.errDiag = 1'b1;
      end else if (!d.errDiag || mediaEvent.errClear) begin
         // Bad-block detection is unsupported, reserved bits stay low
         errNext = errNext & ~`ERR_RESERVED_MASK;
         d.errDiag = 1'b0;
      end
      d.errCause = errNext;

      // Addressing views, rebuilt from the next register values
      d.sectorTotal = (d.sectorCount == 8'h00) ? `SECTOR_COUNT_ZERO_MEANS
                      : {1'b0, d.sectorCount};
      d.mediaAddress = {d.unitHead[3:0], d.cylHigh, d.cylLow, d.sectorNumber};
      d.unitAddressed = (d.unitHead[`UH_UNIT_BIT] == copyNumber);
      d.statusValid = !busyFlag;

      // Host reads: drive only while the strobe stays low
      // Losing selection mid-read also releases the bus
      if (hostBus.iordN || !q.trueIde || !d.unitAddressed) begin
         d.rdOe = 1'b0;
      end
      if (rdStart && priSel && d.unitAddressed) begin
         d.rdOe = 1'b1;
         case (hostBus.addr)
            `OFS_DATA: begin
               d.dataRdStrobe = 1'b1;
               d.rdData = hostBus.byteAccess ? {8'h00, bufferRdWord[7:0]} : bufferRdWord;
            end
            `OFS_ERR_FEATURE: d.rdData = {8'h00, q.errCause};
            `OFS_SECTOR_COUNT: d.rdData = {8'h00, q.sectorCount};
            `OFS_SECTOR_NUMBER: d.rdData = {8'h00, q.sectorNumber};
            `OFS_CYL_LOW: d.rdData = {8'h00, q.cylLow};
            `OFS_CYL_HIGH: d.rdData = {8'h00, q.cylHigh};
            `OFS_UNIT_HEAD: d.rdData = {8'h00, q.unitHead};
            default: begin
               // Status is served by the command block, not this bank
               d.rdOe = 1'b0;
               d.rdData = 16'h0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q <= '0;
         q.iordPrev <= 1'b1;
         q.iowrPrev <= 1'b1;
         q.unitHead <= `RST_UNIT_HEAD;
         q.errCause <= `RST_ERR;
         q.featureSel <= `RST_BYTE;
         q.sectorTotal <= `SECTOR_COUNT_ZERO_MEANS;
         q.mediaAddress <= 28'h0000000;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      hostRdData = q.rdData;
      hostRdOe = q.rdOe;
      dataWrStrobe = q.dataWrStrobe;
      dataWrWord = q.dataWrWord;
      dataWrByte = q.dataWrByte;
      dataRdStrobe = q.dataRdStrobe;
      featureSelect = q.featureSel;
      sectorTotal = q.sectorTotal;
      mediaAddress = q.mediaAddress;
      lbaMode = q.unitHead[`UH_LBA_BIT];
      unitAddressed = q.unitAddressed;
      trueIdeMode = q.trueIde;
      statusValid = q.statusValid;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_err_reserved_zero: assert property (!q.errDiag |-> (q.errCause & 8'hAA) == 8'h00)
      else $error("error register reserved bit set");
   a_unc_sets_bit: assert property (mediaEvent.uncorrectable && !mediaEvent.diagDone
      |=> q.errCause[6])
      else $error("uncorrectable error not flagged");
   a_sector_id_missing_flag_sets_bit: assert property (mediaEvent.idMissing && !mediaEvent.diagDone
      |=> q.errCause[4])
      else $error("missing sector id not flagged");
   a_abort_sets_bit: assert property (mediaEvent.aborted && !mediaEvent.diagDone
      |=> q.errCause[2])
      else $error("aborted command not flagged");
   a_general_sets_bit: assert property (mediaEvent.general && !mediaEvent.diagDone
      |=> q.errCause[0])
      else $error("general error not flagged");
   a_diag_code_held: assert property (mediaEvent.diagDone
      |=> q.errCause == ($past(mediaEvent.diagCode) & 8'h7F))
      else $error("diagnostic code not loaded");
   a_feature_latch: assert property (wrStart && priSel && hostBus.addr == 3'h1
      |=> {8'h00, featureSelect} == ($past(hostBus.wrData) & 16'h00FF))
      else $error("feature byte not latched");
   a_count_zero_full: assert property (q.strapDone && q.sectorCount == 8'h00
      |-> sectorTotal == 9'h100)
      else $error("zero sector count not 256");
   a_block_address: assert property (q.strapDone |-> mediaAddress ==
      {q.unitHead[3:0], q.cylHigh, q.cylLow, q.sectorNumber})
      else $error("block address misassembled");
   a_fixed_ones: assert property (q.unitHead[7] && q.unitHead[5])
      else $error("unit/head fixed bits not one");
   a_foreign_quiet: assert property (hostRdOe |-> unitAddressed)
      else $error("unaddressed card drives bus");
   a_reserved_ignored: assert property (wrStart && altSel && hostBus.addr == 3'h7
      && !mediaEvent.errClear |=> $stable(featureSelect) && $stable(q.unitHead))
      else $error("reserved write had an effect");
   a_read_release: assert property (hostBus.iordN |=> !hostRdOe)
      else $error("data bus held after read strobe");

endmodule
`default_nettype wire

// [host_ctrl_model.sv]
// Host disk controller model: drives the task file strobes of the card.
// Assumes the caller runs on ref_clk and waits for nothing else.
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
   input wire logic ref_clk,
   output var task_file_pkg::host_bus_t hostBus
);
   import task_file_pkg::*;
   initial hostBus = '{1'b1, 1'b1, 3'h0, 1'b1, 1'b1, 1'b0, 16'h0000};
   // One access: strobe low two cycles, then high at least one sampled cycle
   task automatic access(input logic rd, input logic alt, input logic [2:0] a,
         input logic [15:0] d, input logic byteAcc);
      @(negedge ref_clk);
      hostBus.primaryCsN = alt;
      hostBus.alternateCsN = ~alt;
      hostBus.addr = a;
      hostBus.wrData = d;
      hostBus.byteAccess = byteAcc;
      hostBus.iordN = ~rd;
      hostBus.iowrN = rd;
      repeat (2) @(negedge ref_clk);
      hostBus.iordN = 1'b1;
      hostBus.iowrN = 1'b1;
      hostBus.primaryCsN = 1'b1;
      hostBus.alternateCsN = 1'b1;
      // Released lines show the inverse so stale data cannot pass
      hostBus.wrData = ~d;
      hostBus.addr = ~a;
   endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the task file register bank.
// Assumes the package and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import task_file_pkg::*;
   logic ref_clk, reset, copyNumber, busyFlag, oePrev, strapN;
   host_bus_t hostBus;
   media_event_t mediaEvent;
   logic [15:0] bufferRdWord, hostRdData, dataWrWord, w;
   logic hostRdOe, dataWrStrobe, dataWrByte, dataRdStrobe, lbaMode;
   logic unitAddressed, trueIdeMode, statusValid;
   logic [7:0] featureSelect;
   logic [7:0] b [2:5];
   logic [8:0] sectorTotal;
   logic [27:0] mediaAddress;
   logic [16:0] rdQ [$];
   logic [16:0] wrQ [$];
   int error_cnt, tests_run, seed;
   int rdStrobeCnt;
   host_ctrl_model bus (.ref_clk(ref_clk), .hostBus(hostBus));
   task_file_regs dut (.ref_clk(ref_clk), .reset(reset),
      .outputEnableStrapN(strapN),
      .hostBus(hostBus), .mediaEvent(mediaEvent), .bufferRdWord(bufferRdWord),
      .copyNumber(copyNumber), .busyFlag(busyFlag), .hostRdData(hostRdData),
      .hostRdOe(hostRdOe), .dataWrStrobe(dataWrStrobe), .dataWrWord(dataWrWord),
      .dataWrByte(dataWrByte), .dataRdStrobe(dataRdStrobe),
      .featureSelect(featureSelect), .sectorTotal(sectorTotal),
      .mediaAddress(mediaAddress), .lbaMode(lbaMode), .unitAddressed(unitAddressed),
      .trueIdeMode(trueIdeMode), .statusValid(statusValid));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // ------------------------------------------------------------
   // Result watcher: a drive or data write strobe with no note is a mismatch; read strobes are only counted
   // ------------------------------------------------------------
   always @(negedge ref_clk) begin
      if (hostRdOe === 1'b1 && oePrev !== 1'b1) begin
         if (rdQ.size() == 0) check({16'h0001, hostRdData}, {16'h0000, hostRdData});
         else check({1'b0, hostRdData}, rdQ.pop_front());
      end
      oePrev <= hostRdOe;
      if (dataRdStrobe === 1'b1) rdStrobeCnt++;
      if (dataWrStrobe === 1'b1) begin
         if (wrQ.size() == 0) check(32'h1, 32'h0);
         else check({dataWrByte, dataWrWord}, wrQ.pop_front());
      end
   end
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      bus.access(1'b0, 1'b0, a, d, 1'b0);
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      rdQ.push_back({1'b0, e});
      bus.access(1'b1, 1'b0, a, 16'h0000, 1'b0);
   endtask
   task automatic pulse(input media_event_t ev);
      mediaEvent = ev;
      @(negedge ref_clk);
      mediaEvent = '0;
   endtask
   task automatic errTest(input logic [13:0] ev, input logic [7:0] e);
      pulse(media_event_t'(14'h0001));
      pulse(media_event_t'(ev));
      rd(3'h1, {8'h00, e});
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge ref_clk);
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      test_done;
   end
   initial begin
      error_cnt = 0;
      tests_run = 0;
      seed = 17;
      rdStrobeCnt = 0;
      strapN = 1'b0;
      reset = 1'b1;
      copyNumber = 1'b0;
      busyFlag = 1'b0;
      mediaEvent = '0;
      bufferRdWord = 16'h0000;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      repeat (3) @(negedge ref_clk);
      check({featureSelect, sectorTotal, mediaAddress, lbaMode, trueIdeMode},
            {8'h00, 9'h100, 28'h0, 1'b0, 1'b1});
      $display("reset values done");
      for (int a = 2; a <= 5; a++) begin
         w = 16'($random(seed));
         b[a] = w[7:0];
         wr(a[2:0], w);
         rd(a[2:0], {8'h00, w[7:0]});
      end
      wr(3'h6, 16'h0045);
      rd(3'h6, 16'h00E5);
      check({lbaMode, mediaAddress}, {1'b1, 4'h5, b[5], b[4], b[3]});
      check(sectorTotal, (b[2] == 8'h00) ? 9'h100 : {1'b0, b[2]});
      wr(3'h2, 16'h0000);
      check(sectorTotal, 9'h100);
      wr(3'h1, 16'h3355);
      check(featureSelect, 8'h55);
      $display("address registers done");
      for (int i = 0; i < 4; i++) errTest(14'h2000 >> i, 8'h40 >> (2 * i));
      errTest(14'h3C00, 8'h55);
      for (int c = 1; c <= 5; c++) errTest({5'h01, c[7:0], 1'b0}, c[7:0]);
      $display("error register done");
      w = 16'($random(seed));
      wrQ.push_back({1'b0, w});
      bus.access(1'b0, 1'b0, 3'h0, w, 1'b0);
      wrQ.push_back({1'b1, 8'h00, ~w[7:0]});
      bus.access(1'b0, 1'b0, 3'h0, ~w, 1'b1);
      bufferRdWord = 16'($random(seed));
      rd(3'h0, bufferRdWord);
      // Byte read: only the low byte of the buffer word reaches the host
      bufferRdWord = 16'($random(seed));
      rdQ.push_back({9'h000, bufferRdWord[7:0]});
      bus.access(1'b1, 1'b0, 3'h0, 16'h0000, 1'b1);
      $display("data port done");
      copyNumber = 1'b1;
      wr(3'h3, 16'h00A7);
      bus.access(1'b1, 1'b0, 3'h3, 16'h0000, 1'b0);
      check({unitAddressed, mediaAddress[7:0]}, {1'b0, 8'hA7});
      wr(3'h6, 16'h00F0);
      rd(3'h6, 16'h00F0);
      check({unitAddressed, mediaAddress[27:24]}, {1'b1, 4'h0});
      bus.access(1'b0, 1'b1, 3'h7, 16'h00FF, 1'b0);
      bus.access(1'b1, 1'b1, 3'h6, 16'h0000, 1'b0);
      bus.access(1'b1, 1'b0, 3'h7, 16'h0000, 1'b0);
      check({featureSelect, mediaAddress}, {8'h55, 4'h0, b[5], b[4], 8'hA7});
      $display("unit select and refusals done");
      busyFlag = 1'b1;
      repeat (3) @(negedge ref_clk);
      check(statusValid, 1'b0);
      busyFlag = 1'b0;
      repeat (3) @(negedge ref_clk);
      check(statusValid, 1'b1);
      check(rdQ.size() + wrQ.size(), 0);
      check(rdStrobeCnt, 2);
      $display("busy and leftovers done");
      // Strap high across a fresh reset: the bank must stay out of disk mode
      strapN = 1'b1;
      copyNumber = 1'b0;
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      repeat (3) @(negedge ref_clk);
      check({trueIdeMode, unitAddressed, featureSelect}, {1'b0, 1'b1, 8'h00});
      bus.access(1'b1, 1'b0, 3'h2, 16'h0000, 1'b0);
      wr(3'h1, 16'h0077);
      check(featureSelect, 8'h00);
      $display("strap mode done");
      test_done;
   end
endmodule
`default_nettype wire
